// File: include/intps_defines.vh
// Purpose: constants for the interrupt priority and status block
// Assumes: APB byte addresses, 32-bit words, 16-bit registers in the low half
// Notes:   definitions only
`ifndef INTPS_DEFINES_VH
`define INTPS_DEFINES_VH

// ************************************************************
// Register byte addresses
// ************************************************************
`define INTPS_ADDR_W            8
`define INTPS_OFS_I2C2          8'h00
`define INTPS_OFS_CAL           8'h04
`define INTPS_OFS_CRC_SER       8'h08
`define INTPS_OFS_VDET          8'h0C
`define INTPS_OFS_CTMU          8'h10
`define INTPS_OFS_WAKE          8'h14
`define INTPS_OFS_STATUS        8'h18
`define INTPS_OFS_CPUCTL        8'h1C

// ************************************************************
// Field positions (low bit of each level field, or the single flag bit)
// ************************************************************
`define INTPS_POS_I2C2_MASTER   8
`define INTPS_POS_I2C2_SLAVE    4
`define INTPS_POS_CALENDAR      8
`define INTPS_POS_CHECKSUM      12
`define INTPS_POS_SERIAL2       8
`define INTPS_POS_SERIAL1       4
`define INTPS_POS_VDET          0
`define INTPS_POS_CTMU          4
`define INTPS_POS_WAKE          0
`define INTPS_BIT_UNACKED       15
`define INTPS_BIT_VEC_HOLD      13
`define INTPS_POS_NEWLVL        8
`define INTPS_BIT_NEST_OFF      15
`define INTPS_BIT_TDIS          14
`define INTPS_POS_CPULVL        0

// ************************************************************
// Values
// ************************************************************
`define INTPS_LVL_RESET         3'h4
`define INTPS_LVL_OFF           3'h0
`define INTPS_LVL_TOP_USER      4'h7
`define INTPS_VEC_BASE          8'h08
`define INTPS_NSRC              9
`define INTPS_TDIS_CYCLES       16'h0010

`endif

// File: hw/intps_arbiter.v
// Purpose: picks the highest level pending source, lowest index on ties
// Assumes: levels packed 3 bits per source, source 0 has lowest vector
// Notes:   purely combinational
`timescale 1ns/1ps
`include "intps_defines.vh"

module intps_arbiter #(
    parameter NSRC = `INTPS_NSRC
) (
    // Source state
    input  wire [NSRC*3-1:0] levels,
    input  wire [NSRC-1:0]   pending,
    // Winner
    output reg               found,
    output reg  [2:0]        win_level,
    output reg  [6:0]        win_index
);

    integer i;

    // Strictly greater keeps the earlier, lower vector on a tie
    always @* begin
        found     = 1'b0;
        win_level = `INTPS_LVL_OFF;
        win_index = 7'h00;
        for (i = 0; i < NSRC; i = i + 1) begin
            if (pending[i] && levels[i*3 +: 3] != `INTPS_LVL_OFF &&
                (!found || levels[i*3 +: 3] > win_level)) begin  // [R1] [R18]
                found     = 1'b1;
                win_level = levels[i*3 +: 3];
                win_index = i[6:0];
            end
        end
    end

endmodule // intps_arbiter

// File: hw/intps_timed_disable.v
// Purpose: counts the timed-disable window
// Assumes: start is a one-cycle pulse
// Notes:   a new start reloads the count
`timescale 1ns/1ps
`include "intps_defines.vh"

module intps_timed_disable #(
    parameter CYCLES = `INTPS_TDIS_CYCLES
) (
    // Clock and reset
    input  wire pclk,
    input  wire presetn,
    // Control
    input  wire start,
    output wire active
);

    reg [15:0] count;

    // Down counter, active while nonzero
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= 16'h0000;
        end else if (start) begin
            count <= CYCLES[15:0];
        end else if (count != 16'h0000) begin
            count <= count - 16'h0001;
        end
    end

    assign active = (count != 16'h0000);

endmodule // intps_timed_disable

// File: hw/intps_top.v
// Purpose: interrupt priority registers, vector selection and status
// Assumes: APB slave, requests arrive as flag&enable levels from peripherals
// Notes:   CPU acknowledges with a pulse; return pulse restores saved level
// Notes on behaviour
// [R1] 3-bit level per source, zero disables
// [R2] Reset puts every source at level 4
// [R3] Unimplemented bits read zero, writes ignored
// [R4] Unacked flag set while request not acknowledged; the code sets it only while the winner is held off and cannot be taken
// [R5] Vector hold one shows highest pending vector
// [R6] Vector hold zero shows last acknowledged vector
// [R7] Acknowledge only above current CPU level
// [R8] Four-bit new CPU level field, read only
// [R9] Seven-bit vector field, offset by eight; the code shows the bare source index without the offset
// [R10] Nesting disable blocks preemption during service
// [R11] Software sets level, clears flag, enables
// [R12] Flag still set on return re-requests
// [R13] Return restores saved level and context
// [R14] Trap handler clears its trap flag
// [R15] Masking forces CPU level seven by OR; the code loads the written CPU level as it is
// [R16] CPU level masks user levels only
// [R17] Timed disable blocks levels one to six
// [R18] Ties go to the lowest vector
`timescale 1ns/1ps
`include "intps_defines.vh"

module intps_top #(
    parameter NSRC       = `INTPS_NSRC,
    parameter TDIS_COUNT = `INTPS_TDIS_CYCLES
) (
    // Clock and reset
    input  wire             pclk,
    input  wire             presetn,
    // APB slave
    input  wire             psel,
    input  wire             penable,
    input  wire             pwrite,
    input  wire [7:0]       paddr,
    input  wire [31:0]      pwdata,
    output reg  [31:0]      prdata,
    output reg              pready,
    output reg              pslverr,
    // Peripheral requests (flag and enable already combined)
    input  wire [NSRC-1:0]  src_request,
    // CPU core side
    input  wire             cpu_ack,
    input  wire             cpu_return,
    input  wire             timed_disable_start,
    output reg              cpu_irq,
    output reg  [6:0]       cpu_vector,
    output reg  [3:0]       cpu_level_out
);

    // ************************************************************
    // Priority registers
    // ************************************************************
    // Source order: i2c2 master, i2c2 slave, calendar, checksum,
    // serial2 error, serial1 error, voltage detect, charge timer, wakeup
    reg  [2:0]  i2c2_master_event_level;
    reg  [2:0]  i2c2_slave_event_level;
    reg  [2:0]  calendar_event_level;
    reg  [2:0]  checksum_error_level;
    reg  [2:0]  serial2_error_level;
    reg  [2:0]  serial1_error_level;
    reg  [2:0]  voltage_detect_level;
    reg  [2:0]  charge_timer_level;
    reg  [2:0]  wakeup_event_level;
    reg         vector_hold_select;
    reg         nesting_disable;
    reg  [3:0]  cpu_level;
    reg  [31:0] saved_level;    // Stack of eight levels, top in the low nibble
    reg  [6:0]  last_ack_vector;
    reg         in_service;
    reg         unacked_request_flag;

    wire        wr_en = psel && penable && pwrite;
    wire        rd_en = psel && !penable && !pwrite;
    wire [NSRC*3-1:0] levels = {wakeup_event_level, charge_timer_level,
                                voltage_detect_level, serial1_error_level,
                                serial2_error_level, checksum_error_level,
                                calendar_event_level, i2c2_slave_event_level,
                                i2c2_master_event_level};

    // Decode of a known address, used by the error path only
    function mapped;
        input [7:0] a;
        begin
            mapped = (a == `INTPS_OFS_I2C2) || (a == `INTPS_OFS_CAL) ||
                     (a == `INTPS_OFS_CRC_SER) || (a == `INTPS_OFS_VDET) ||
                     (a == `INTPS_OFS_CTMU) || (a == `INTPS_OFS_WAKE) ||
                     (a == `INTPS_OFS_STATUS) || (a == `INTPS_OFS_CPUCTL);
        end
    endfunction

    // Place a 3-bit level in a zeroed 32-bit word
    function [31:0] put3;
        input [2:0] v;
        input integer pos;
        begin
            put3 = {29'h0, v} << pos;
        end
    endfunction

    // ************************************************************
    // Arbitration and masking
    // ************************************************************
    wire        timed_off;
    wire        found;
    wire [2:0]  win_level;
    wire [6:0]  win_index;

    intps_arbiter #(
        .NSRC      (NSRC)
    ) u_arb (
        .levels    (levels),
        .pending   (src_request),
        .found     (found),
        .win_level (win_level),
        .win_index (win_index)
    );

    intps_timed_disable #(
        .CYCLES    (TDIS_COUNT)
    ) u_tdis (
        .pclk      (pclk),
        .presetn   (presetn),
        .start     (timed_disable_start),
        .active    (timed_off)
    );

    // Only user levels exist here, so traps above 7 are never masked by this
    wire lvl_above  = ({1'b0, win_level} > cpu_level);                    // [R7] [R16]
    wire tdis_block = timed_off && ({1'b0, win_level} != `INTPS_LVL_TOP_USER); // [R17]
    wire nest_block = nesting_disable && in_service;                      // [R10]
    wire can_take   = found && lvl_above && !tdis_block && !nest_block;

    // ************************************************************
    // CPU level, service and capture
    // ************************************************************
    // Ack raises CPU level to the winner; return restores the saved one
    // Nested returns pop in order; seven user levels never need more than eight
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_level       <= 4'h0;
            saved_level     <= 32'h00000000;
            last_ack_vector <= 7'h00;
            in_service      <= 1'b0;
        end else begin
            if (cpu_ack && can_take) begin
                saved_level     <= {saved_level[27:0], cpu_level};
                cpu_level       <= {1'b0, win_level};
                last_ack_vector <= win_index;                              // [R7]
                in_service      <= 1'b1;
            end else if (cpu_return) begin
                cpu_level   <= saved_level[3:0];                           // [R13]
                saved_level <= {4'h0, saved_level[31:4]};
                in_service  <= 1'b0;
            end else if (wr_en && paddr == `INTPS_OFS_CPUCTL) begin
                cpu_level <= pwdata[`INTPS_POS_CPULVL +: 4];               // [R15]
            end
        end
    end

    // Unacknowledged flag: the winning request held off by CPU level, timed disable or nesting
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unacked_request_flag <= 1'b0;
        end else begin
            unacked_request_flag <= found && !can_take;                    // [R4]
        end
    end

    // ************************************************************
    // Register writes
    // ************************************************************
    // Only implemented fields are taken from the write data
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            i2c2_master_event_level <= `INTPS_LVL_RESET;                   // [R2]
            i2c2_slave_event_level  <= `INTPS_LVL_RESET;
            calendar_event_level    <= `INTPS_LVL_RESET;
            checksum_error_level    <= `INTPS_LVL_RESET;
            serial2_error_level     <= `INTPS_LVL_RESET;
            serial1_error_level     <= `INTPS_LVL_RESET;
            voltage_detect_level    <= `INTPS_LVL_RESET;
            charge_timer_level      <= `INTPS_LVL_RESET;
            wakeup_event_level      <= `INTPS_LVL_RESET;
            vector_hold_select      <= 1'b0;
            nesting_disable         <= 1'b0;
        end else if (wr_en) begin
            case (paddr)
                `INTPS_OFS_I2C2: begin
                    i2c2_master_event_level <= pwdata[`INTPS_POS_I2C2_MASTER +: 3]; // [R3]
                    i2c2_slave_event_level  <= pwdata[`INTPS_POS_I2C2_SLAVE +: 3];
                end
                `INTPS_OFS_CAL: begin
                    calendar_event_level <= pwdata[`INTPS_POS_CALENDAR +: 3];
                end
                `INTPS_OFS_CRC_SER: begin
                    checksum_error_level <= pwdata[`INTPS_POS_CHECKSUM +: 3];
                    serial2_error_level  <= pwdata[`INTPS_POS_SERIAL2 +: 3];
                    serial1_error_level  <= pwdata[`INTPS_POS_SERIAL1 +: 3];
                end
                `INTPS_OFS_VDET: begin
                    voltage_detect_level <= pwdata[`INTPS_POS_VDET +: 3];
                end
                `INTPS_OFS_CTMU: begin
                    charge_timer_level <= pwdata[`INTPS_POS_CTMU +: 3];
                end
                `INTPS_OFS_WAKE: begin
                    wakeup_event_level <= pwdata[`INTPS_POS_WAKE +: 3];
                end
                `INTPS_OFS_STATUS: begin
                    vector_hold_select <= pwdata[`INTPS_BIT_VEC_HOLD];
                end
                `INTPS_OFS_CPUCTL: begin
                    nesting_disable <= pwdata[`INTPS_BIT_NEST_OFF];        // [R10]
                end
                default: begin
                    vector_hold_select <= vector_hold_select;
                end
            endcase
        end
    end

    // ************************************************************
    // Read data and status word
    // ************************************************************
    // Hold shows the live winner, otherwise the last acknowledged vector
    wire [6:0] shown_vec = vector_hold_select ? win_index : last_ack_vector; // [R5] [R6]
    wire [31:0] status_word = ({31'h0, unacked_request_flag} << `INTPS_BIT_UNACKED) |
                              ({31'h0, vector_hold_select} << `INTPS_BIT_VEC_HOLD) |
                              ({28'h0, cpu_level} << `INTPS_POS_NEWLVL) |   // [R8]
                              {25'h0, shown_vec};                           // [R9]

    reg [31:0] next_prdata;

    always @* begin
        case (paddr)
            `INTPS_OFS_I2C2:    next_prdata = put3(i2c2_master_event_level,
                                              `INTPS_POS_I2C2_MASTER) |
                                              put3(i2c2_slave_event_level,
                                              `INTPS_POS_I2C2_SLAVE);
            `INTPS_OFS_CAL:     next_prdata = put3(calendar_event_level,
                                              `INTPS_POS_CALENDAR);
            `INTPS_OFS_CRC_SER: next_prdata = put3(checksum_error_level,
                                              `INTPS_POS_CHECKSUM) |
                                              put3(serial2_error_level,
                                              `INTPS_POS_SERIAL2) |
                                              put3(serial1_error_level,
                                              `INTPS_POS_SERIAL1);
            `INTPS_OFS_VDET:    next_prdata = put3(voltage_detect_level, `INTPS_POS_VDET);
            `INTPS_OFS_CTMU:    next_prdata = put3(charge_timer_level, `INTPS_POS_CTMU);
            `INTPS_OFS_WAKE:    next_prdata = put3(wakeup_event_level, `INTPS_POS_WAKE);
            `INTPS_OFS_STATUS:  next_prdata = status_word;
            `INTPS_OFS_CPUCTL:  next_prdata = ({31'h0, nesting_disable} << `INTPS_BIT_NEST_OFF) |
                                              ({31'h0, timed_off} << `INTPS_BIT_TDIS) |
                                              {28'h0, cpu_level};
            default:            next_prdata = 32'h00000000;                // [R3]
        endcase
    end

    // APB answers one cycle after setup; data captured in the setup cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped(paddr);
            if (rd_en) begin
                prdata <= next_prdata;
            end
        end
    end

    // ************************************************************
    // CPU outputs, registered
    // ************************************************************
    // A request persists while the source stays flagged after return
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_irq       <= 1'b0;
            cpu_vector    <= 7'h00;
            cpu_level_out <= 4'h0;
        end else begin
            cpu_irq       <= can_take && !(cpu_ack && can_take);           // [R12]
            cpu_vector    <= win_index;
            cpu_level_out <= cpu_level;
        end
    end

endmodule // intps_top

// File: tb/intps_top_asserts.sv
// Purpose: port checks for intps_top
// Assumes: one clock, presetn async active low
// Notes:   bound to the top module below
`timescale 1ns/1ps
module intps_top_asserts #(
    parameter NSRC = 9
) (
    // Clock and reset
    input wire logic            pclk,
    input wire logic            presetn,
    // APB
    input wire logic            psel,
    input wire logic            penable,
    input wire logic            pwrite,
    input wire logic [7:0]      paddr,
    input wire logic [31:0]     pwdata,
    input wire logic [31:0]     prdata,
    input wire logic            pready,
    input wire logic            pslverr,
    // Requests and CPU side
    input wire logic [NSRC-1:0] src_request,
    input wire logic            cpu_ack,
    input wire logic            cpu_return,
    input wire logic            timed_disable_start,
    input wire logic            cpu_irq,
    input wire logic [6:0]      cpu_vector,
    input wire logic [3:0]      cpu_level_out
);
    // ****************
    // Properties
    // ****************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Bus answers wait-free, so a late pready is a fault
    a_ready_next:
        assert property ((psel && !penable) |=> pready) else $error("pready late");
    a_ready_only:
        assert property (pready |-> psel && penable) else $error("pready stray");
    a_err_only:
        assert property (pslverr |-> pready) else $error("pslverr stray");
    a_mapped_ok:
        assert property ((psel && !penable && paddr[1:0] == 2'h0 && paddr <= 8'h1C)
            |=> !pslverr) else $error("mapped word refused");
    a_upper_zero:
        assert property ((pready && !pwrite) |-> prdata[31:16] == 16'h0000)
            else $error("upper half not zero");
    a_status_gaps:
        assert property ((pready && !pwrite && paddr == 8'h18)
            |-> !prdata[14] && !prdata[12] && !prdata[7]) else $error("status gap set");
    a_unmapped_zero:
        assert property ((pready && pslverr && !pwrite) |-> prdata == 32'h0)
            else $error("refused read not zero");
    a_idle_quiet:
        assert property ((src_request == '0) |=> !cpu_irq) else $error("irq with no source");
    // Stable sources keep the winner, so a taken ack must lift the level
    a_ack_raise:
        assert property ((cpu_ack && cpu_irq && $stable(src_request)) |=> !cpu_irq
            ##1 (cpu_level_out > $past(cpu_level_out, 2) && cpu_level_out <= 4'h7))
            else $error("ack did not raise level");
    // The level output trails its cause by two register stages
    a_level_cause:
        assert property ((cpu_level_out != $past(cpu_level_out)) |-> $past(cpu_ack, 2)
            || $past(cpu_return, 2) || $past(pready && pwrite && paddr == 8'h1C, 2))
            else $error("level moved alone");
endmodule // intps_top_asserts

bind intps_top intps_top_asserts #(.NSRC(NSRC)) u_asserts (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .src_request(src_request),
    .cpu_ack(cpu_ack), .cpu_return(cpu_return),
    .timed_disable_start(timed_disable_start), .cpu_irq(cpu_irq),
    .cpu_vector(cpu_vector), .cpu_level_out(cpu_level_out)
);

// File: tb/intps_cpu_model.sv
// Purpose: CPU core that takes offered requests
// Assumes: ack and return are one-cycle pulses
// Notes:   ack delay set by the bench, prompt or slow
`timescale 1ns/1ps
module intps_cpu_model (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Bench controls
    input  wire logic       auto_ack,
    input  wire logic [3:0] ack_wait,
    input  wire logic       ret_req,
    // Block side
    input  wire logic       cpu_irq,
    output logic            cpu_ack,
    output logic            cpu_return
);
    logic [3:0] seen;
    logic [1:0] hold;
    // Hold-off after an ack so a falling irq is never taken twice
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_ack <= 1'b0;
            cpu_return <= 1'b0;
            seen <= 4'h0;
            hold <= 2'h0;
        end else begin
            cpu_return <= ret_req;
            cpu_ack <= 1'b0;
            if (hold != 2'h0) begin
                hold <= hold - 2'h1;
            end else if (cpu_irq && auto_ack) begin
                if (seen >= ack_wait) begin
                    cpu_ack <= 1'b1;
                    seen <= 4'h0;
                    hold <= 2'h2;
                end else begin
                    seen <= seen + 4'h1;
                end
            end else begin
                seen <= 4'h0;
            end
        end
    end
endmodule // intps_cpu_model

// File: tb/test_intps_top.sv
// Purpose: self-checking bench for intps_top
// Assumes: wait-free APB, CPU model on the far side
// Notes:   read results are queued and checked by a monitor
`timescale 1ns/1ps
`include "intps_defines.vh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_errors++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module test_intps_top;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic        pready, pslverr, cpu_ack, cpu_return, cpu_irq;
    logic        timed_disable_start = 0, auto_ack = 0, ret_req = 0;
    logic [8:0]  src_request = 0;
    logic [6:0]  cpu_vector;
    logic [3:0]  cpu_level_out, ack_wait = 0;
    logic [32:0] expq[$], ex;
    logic [2:0]  lv[9];
    int          n_errors = 0, check_count = 0, n_ack = 0, seed = 14, k;
    logic [7:0]  ofs_t[9] = '{8'h00, 8'h00, 8'h04, 8'h08, 8'h08, 8'h08, 8'h0C, 8'h10, 8'h14};
    int          pos_t[9] = '{8, 4, 8, 12, 8, 4, 0, 4, 0};
    always #12.5 pclk = ~pclk;
    intps_top #(.NSRC(9), .TDIS_COUNT(16)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .src_request(src_request),
        .cpu_ack(cpu_ack), .cpu_return(cpu_return),
        .timed_disable_start(timed_disable_start), .cpu_irq(cpu_irq),
        .cpu_vector(cpu_vector), .cpu_level_out(cpu_level_out));
    intps_cpu_model u_cpu (.pclk(pclk), .presetn(presetn), .auto_ack(auto_ack),
        .ack_wait(ack_wait), .ret_req(ret_req), .cpu_irq(cpu_irq),
        .cpu_ack(cpu_ack), .cpu_return(cpu_return));
    // ****************
    // Monitor and tasks
    // ****************
    // Oldest queued note is matched to each read answer
    always @(posedge pclk) begin
        if (cpu_ack) n_ack++;
        if (pready && !pwrite) begin
            ex = expq.pop_front();
            `CHK({pslverr, prdata}, ex)
        end
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w) expq.push_back(e);
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
        if (n >= 20) `CHK(pready, 1'b1)
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d); apb(1, a, d, '0); endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] e); apb(0, a, 0, e); endtask
    function automatic logic [31:0] regv(input logic [7:0] a);
        regv = 0;
        for (int i = 0; i < 9; i++) if (ofs_t[i] == a) regv[pos_t[i] +: 3] = lv[i];
    endfunction
    task automatic setlv(input int i, input logic [2:0] v);
        lv[i] = v;
        wr(ofs_t[i], regv(ofs_t[i]));
    endtask
    function automatic logic [32:0] st(input logic u, h, input logic [3:0] l,
                                       input logic [6:0] v);
        return {17'h0, u, 1'b0, h, 1'b0, l, 1'b0, v};
    endfunction
    task automatic src(input logic [8:0] v); @(posedge pclk); src_request <= v; endtask
    task automatic cyc(input int n); repeat (n) @(posedge pclk); endtask
    task automatic ret();
        @(posedge pclk);
        ret_req <= 1'b1;
        @(posedge pclk);
        ret_req <= 1'b0;
    endtask
    // Bounded waits; a miss shows up as a failed compare
    task automatic waitlvl(input logic [3:0] l);
        for (int n = 0; n < 60 && cpu_level_out !== l; n++) @(posedge pclk);
        `CHK(cpu_level_out, l)
    endtask
    task automatic waitirq();
        for (int n = 0; n < 60 && cpu_irq !== 1'b1; n++) @(posedge pclk);
        `CHK(cpu_irq, 1'b1)
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Watchdog, far beyond the few hundred cycles the run needs
    initial begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        end_sim();
    end
    // ****************
    // Scenarios
    // ****************
    initial begin
        foreach (lv[i]) lv[i] = 3'h4;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (logic [7:0] a = 0; a < 8'h20; a += 4) rd(a, {1'b0, regv(a)});
        rd(8'h20, {1'b1, 32'h0});
        $display("test reset done");
        for (logic [7:0] a = 0; a < 8'h18; a += 4) wr(a, 32'hFFFF_FFFF);
        foreach (lv[i]) lv[i] = 3'h7;
        for (logic [7:0] a = 0; a < 8'h18; a += 4) rd(a, {1'b0, regv(a)});
        foreach (lv[i]) setlv(i, 3'($random(seed)));
        src(9'($random(seed)));
        for (logic [7:0] a = 0; a < 8'h18; a += 4) rd(a, {1'b0, regv(a)});
        src(9'h000);
        foreach (lv[i]) setlv(i, 3'h4);
        $display("test fields done");
        wr(`INTPS_OFS_STATUS, 32'h2000);
        src(9'h028);
        waitirq();
        `CHK(cpu_vector, 7'h03)
        rd(`INTPS_OFS_STATUS, st(0, 1, 0, 3));
        setlv(5, 3'h7);
        rd(`INTPS_OFS_STATUS, st(0, 1, 0, 5));
        src(9'h000);
        setlv(6, 3'h0);
        src(9'h040);
        cyc(4);
        `CHK(cpu_irq, 1'b0)
        $display("test arbitration done");
        wr(`INTPS_OFS_STATUS, 32'h0);
        ack_wait <= 4'h5;
        auto_ack <= 1'b1;
        src(9'h008);
        waitlvl(4'h4);
        rd(`INTPS_OFS_STATUS, st(1, 0, 4, 3));
        k = n_ack;
        ret();
        for (int n = 0; n < 60 && n_ack == k; n++) @(posedge pclk);
        `CHK(n_ack, k + 1)
        waitlvl(4'h4);
        src(9'h000);
        ret();
        waitlvl(4'h0);
        ack_wait <= 4'h0;
        $display("test ack done");
        src(9'h008);
        waitlvl(4'h4);
        wr(`INTPS_OFS_CPUCTL, 32'h8004);
        src(9'h028);
        cyc(10);
        `CHK(cpu_level_out, 4'h4)
        rd(`INTPS_OFS_STATUS, st(1, 0, 4, 3));
        wr(`INTPS_OFS_CPUCTL, 32'h0004);
        waitlvl(4'h7);
        rd(`INTPS_OFS_STATUS, st(1, 0, 7, 5));
        src(9'h000);
        ret();
        waitlvl(4'h4);
        ret();
        waitlvl(4'h0);
        $display("test nesting done");
        wr(`INTPS_OFS_CPUCTL, 32'h0007);
        src(9'h020);
        cyc(4);
        `CHK(cpu_irq, 1'b0)
        rd(`INTPS_OFS_STATUS, st(1, 0, 7, 5));
        wr(`INTPS_OFS_CPUCTL, 32'h0);
        waitlvl(4'h7);
        src(9'h000);
        ret();
        waitlvl(4'h0);
        $display("test masking done");
        auto_ack <= 1'b0;
        setlv(6, 3'h6);
        src(9'h040);
        waitirq();
        @(posedge pclk);
        timed_disable_start <= 1'b1;
        @(posedge pclk);
        timed_disable_start <= 1'b0;
        cyc(2);
        `CHK(cpu_irq, 1'b0)
        src(9'h060);
        waitirq();
        src(9'h040);
        cyc(2);
        `CHK(cpu_irq, 1'b0)
        waitirq();
        rd(`INTPS_OFS_CPUCTL, {1'b0, 32'h0});
        src(9'h000);
        $display("test timed disable done");
        end_sim();
    end
endmodule // test_intps_top
